/* core/pbs_sram_access.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"
// Contract
// - inputs captured in registers at rising edge; read data leaves from output registers
// - clock_qualify_n high makes the edge ignored; pipeline and output state hold unless sleep is active
// - qualified edge, all selects active, strobe high, load low starts a read
// - read data appears after the edge following the address edge
// - drivers enabled only with output_drive_n low and internal logic allowing
// - new command accepted in the second clock of a read, no wait states
// - deselect at an edge tri-states outputs after the following edge
// - burst counter steps through four addresses from one loaded address, repeating them on further advances
// - order strap low gives linear, high gives interleaved bursts
// - burst sequencing uses the two lowest address bits and wraps
// - advance_or_load high advances the burst whatever selects and strobe do
// - access direction latched at burst start and kept through the burst
// - sleep_request high gives a quiet sleep state that keeps stored data
// - writes qualified by write strobe; byte lane masks select written bytes
// - outputs off during write data phase, first clock after deselect, deselected
// - write data presented and latched two edges after the address edge
// - device comes out of reset deselected with data pins tri-stated

module pbs_sram_access (
   input  wire logic                      CLK,
   input  wire logic                      RST,
   input  wire logic                      CLOCK_QUALIFY_N,
   input  wire logic                      SELECT_ONE_N,
   input  wire logic                      SELECT_TWO,
   input  wire logic                      SELECT_THREE_N,
   input  wire logic                      ADVANCE_OR_LOAD,
   input  wire logic                      WRITE_STROBE_N,
   input  wire logic [`PBS_LANES-1:0]     BYTE_LANE_MASK_N,
   input  wire logic [`PBS_ADDR_W-1:0]    ADDRESS,
   input  wire logic                      OUTPUT_DRIVE_N,
   input  wire logic                      SLEEP_REQUEST,
   input  wire logic                      BURST_ORDER,
   input  wire logic [`PBS_DATA_W-1:0]    DATA_IN,
   output logic      [`PBS_DATA_W-1:0]    DATA_OUT,
   output logic                           DATA_OE_N,
   input  wire logic [`PBS_LANES-1:0]     PARITY_IN,
   output logic      [`PBS_LANES-1:0]     PARITY_OUT,
   output logic                           PARITY_OE_N,
   output logic                           SLEEP_ACTIVE
);

   localparam int UPPER_W = `PBS_ADDR_W - `PBS_BURST_W;

   // two-flop synchronisers for the asynchronous pins and the strap
   logic oe_meta;
   logic oe_n_q;
   logic sleep_meta;
   logic sleep_q;
   logic order_meta;
   logic order_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         oe_meta    <= `PBS_OE_N_IDLE;
         oe_n_q     <= `PBS_OE_N_IDLE;
         sleep_meta <= `PBS_SLEEP_IDLE;
         sleep_q    <= `PBS_SLEEP_IDLE;
         order_meta <= `PBS_ORDER_IDLE;
         order_q    <= `PBS_ORDER_IDLE;
      end else begin
         oe_meta    <= OUTPUT_DRIVE_N;
         oe_n_q     <= oe_meta;
         sleep_meta <= SLEEP_REQUEST;
         sleep_q    <= sleep_meta;
         order_meta <= BURST_ORDER;
         order_q    <= order_meta;
      end
   end

   // command decode at the pins
   logic qual;
   logic all_sel;
   logic begin_access;
   logic advance;

   assign qual         = !CLOCK_QUALIFY_N;
   assign all_sel      = !SELECT_ONE_N && SELECT_TWO && !SELECT_THREE_N;
   assign begin_access = qual && !ADVANCE_OR_LOAD && all_sel && !sleep_q;
   assign advance      = qual && ADVANCE_OR_LOAD && !sleep_q;

   // burst state: direction and upper address held from the loading edge
   pbs_pkg::pbs_cmd_t burst_type;
   logic [UPPER_W-1:0] base_upper;
   logic [`PBS_BURST_W-1:0] seq_low;

   always_ff @(posedge CLK) begin
      if (RST) begin
         burst_type <= pbs_pkg::PBS_IDLE;
      end else if (sleep_q) begin
         burst_type <= pbs_pkg::PBS_IDLE;
      end else if (qual && !ADVANCE_OR_LOAD) begin
         if (!all_sel) begin
            burst_type <= pbs_pkg::PBS_IDLE;
         end else if (WRITE_STROBE_N) begin
            burst_type <= pbs_pkg::PBS_READ;
         end else begin
            burst_type <= pbs_pkg::PBS_WRITE;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         base_upper <= `PBS_UPPER_ZERO;
      end else if (begin_access) begin
         base_upper <= ADDRESS[`PBS_ADDR_W-1:`PBS_BURST_W];
      end
   end

   pbs_burst_seq u_burst (
      .clk       (CLK),
      .rst       (RST),
      .load      (begin_access),
      .advance   (advance),
      .start_low (ADDRESS[`PBS_BURST_W-1:0]),
      .order     (order_q),
      .next_low  (seq_low)
   );

   // stage one: the access registered at its address edge
   pbs_pkg::pbs_cmd_t s1_cmd;
   pbs_pkg::pbs_cmd_t next_cmd;
   logic [`PBS_ADDR_W-1:0] s1_addr;
   logic [`PBS_ADDR_W-1:0] next_addr;
   logic [`PBS_LANES-1:0] s1_mask;
   logic [`PBS_LANES-1:0] next_mask;

   always_comb begin
      next_cmd  = s1_cmd;
      next_addr = s1_addr;
      next_mask = s1_mask;
      if (qual) begin
         next_mask = BYTE_LANE_MASK_N;
         if (sleep_q) begin
            next_cmd = pbs_pkg::PBS_IDLE;
         end else if (ADVANCE_OR_LOAD) begin
            next_cmd  = burst_type;
            next_addr = {base_upper, seq_low};
         end else if (all_sel) begin
            next_cmd  = WRITE_STROBE_N ? pbs_pkg::PBS_READ : pbs_pkg::PBS_WRITE;
            next_addr = ADDRESS;
         end else begin
            next_cmd = pbs_pkg::PBS_IDLE;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s1_cmd  <= pbs_pkg::PBS_IDLE;
         s1_addr <= {`PBS_ADDR_W{1'b0}};
         s1_mask <= `PBS_MASK_NONE;
      end else begin
         s1_cmd  <= next_cmd;
         s1_addr <= next_addr;
         s1_mask <= next_mask;
      end
   end

   // stage two: write data phase, data taken from the pins at the following edge
   pbs_pkg::pbs_cmd_t s2_cmd;
   logic [`PBS_ADDR_W-1:0] s2_addr;
   logic [`PBS_LANES-1:0] s2_mask;
   logic mem_wr;

   always_ff @(posedge CLK) begin
      if (RST) begin
         s2_cmd  <= pbs_pkg::PBS_IDLE;
         s2_addr <= {`PBS_ADDR_W{1'b0}};
         s2_mask <= `PBS_MASK_NONE;
      end else if (qual) begin
         s2_cmd  <= (s1_cmd == pbs_pkg::PBS_WRITE) ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_IDLE;
         s2_addr <= s1_addr;
         s2_mask <= s1_mask;
      end
   end

   // a write still in the pipe when sleep takes hold is dropped, keeping stored data
   assign mem_wr = qual && (s2_cmd == pbs_pkg::PBS_WRITE) && !sleep_q;

   logic [`PBS_DATA_W-1:0] rd_data;
   logic [`PBS_LANES-1:0] rd_par;

   pbs_core_mem u_mem (
      .clk       (CLK),
      .wr_en     (mem_wr),
      .wr_addr   (s2_addr),
      .wr_mask_n (s2_mask),
      .wr_data   (DATA_IN),
      .wr_par    (PARITY_IN),
      .rd_addr   (s1_addr),
      .rd_data   (rd_data),
      .rd_par    (rd_par)
   );

   // output register stage
   logic out_valid;

   always_ff @(posedge CLK) begin
      if (RST) begin
         out_valid <= 1'b0;
      end else if (sleep_q) begin
         out_valid <= 1'b0;
      end else if (qual) begin
         out_valid <= (s1_cmd == pbs_pkg::PBS_READ);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         DATA_OUT   <= `PBS_DATA_ZERO;
         PARITY_OUT <= `PBS_PAR_ZERO;
      end else if (qual && s1_cmd == pbs_pkg::PBS_READ) begin
         DATA_OUT   <= rd_data;
         PARITY_OUT <= rd_par;
      end
   end

   assign DATA_OE_N    = !(out_valid && !oe_n_q);
   assign PARITY_OE_N  = DATA_OE_N;
   assign SLEEP_ACTIVE = sleep_q;

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   AST_READ_LATENCY: assert property (
      begin_access && WRITE_STROBE_N ##1 qual |=> out_valid && DATA_OUT == $past(rd_data))
      else $error("read data not presented one qualified edge after address");

   AST_SUSPEND_HOLD: assert property (
      CLOCK_QUALIFY_N && !sleep_q |=> $stable(s1_cmd) && $stable(s2_cmd) && $stable(DATA_OUT)
         && $stable(out_valid))
      else $error("state changed on an unqualified edge");

   AST_DESELECT_PIPE: assert property (
      qual && !ADVANCE_OR_LOAD && !all_sel ##1 qual |=> DATA_OE_N)
      else $error("outputs still driven after deselect pipeline");

   AST_WRITE_NO_DRIVE: assert property (
      s2_cmd == pbs_pkg::PBS_WRITE |-> DATA_OE_N && PARITY_OE_N)
      else $error("outputs driven during write data phase");

   AST_DRIVE_NEEDS_OE: assert property (
      !DATA_OE_N |-> !oe_n_q && out_valid)
      else $error("drivers on without output enable and read");

   AST_BURST_KEEP: assert property (
      advance |=> s1_cmd == $past(burst_type)
         && s1_addr[`PBS_ADDR_W-1:`PBS_BURST_W] == $past(base_upper))
      else $error("burst lost its direction or upper address");

   AST_BURST_ORDER: assert property (
      begin_access ##1 advance |=> s1_addr[`PBS_BURST_W-1:0] ==
         ((order_q == `PBS_ORDER_LINEAR) ? $past(ADDRESS[`PBS_BURST_W-1:0], 2) + `PBS_STEP_ONE
                                         : $past(ADDRESS[`PBS_BURST_W-1:0], 2) ^ `PBS_STEP_ONE))
      else $error("burst second address wrong for the order");

   AST_SLEEP_QUIET: assert property (
      sleep_q |=> DATA_OE_N && s1_cmd == pbs_pkg::PBS_IDLE && !mem_wr)
      else $error("activity while asleep");

   AST_WRITE_AT_TWO: assert property (
      begin_access && !WRITE_STROBE_N ##1 qual ##1 qual |-> mem_wr)
      else $error("write not completed two edges after address");

   AST_RESET_OFF: assert property (
      $past(RST) |-> DATA_OE_N && s1_cmd == pbs_pkg::PBS_IDLE)
      else $error("not deselected after reset");

   // output stage: data moves only on read edges, drivers follow the synced enable
   AST_DATA_HOLD: assert property (
      !(qual && s1_cmd == pbs_pkg::PBS_READ) |=> $stable(DATA_OUT))
      else $error("read data register changed without a read");

   AST_DRIVE_ON_READ: assert property (
      qual && s1_cmd == pbs_pkg::PBS_READ && !sleep_q && !oe_meta |=> !DATA_OE_N)
      else $error("read data not driven with output enable low");

   // write edges must leave the drivers off; deselect edges must idle stage one
   AST_WRITE_MASKS_OUT: assert property (
      qual && s1_cmd == pbs_pkg::PBS_WRITE |=> DATA_OE_N && PARITY_OE_N)
      else $error("drivers on while a write moves to its data phase");

   AST_DESELECT_IDLE: assert property (
      qual && !ADVANCE_OR_LOAD && !all_sel |=> s1_cmd == pbs_pkg::PBS_IDLE)
      else $error("deselect edge did not idle the pipeline");

   COV_READ: cover property (begin_access && WRITE_STROBE_N ##1 qual ##1 !DATA_OE_N);
   COV_WRITE: cover property (begin_access && !WRITE_STROBE_N ##1 qual ##1 mem_wr);
   COV_BURST4: cover property (begin_access ##1 advance ##1 advance ##1 advance);
   COV_SUSPEND: cover property (out_valid && CLOCK_QUALIFY_N);
   COV_INTERLEAVED: cover property (begin_access && order_q ##1 advance);

endmodule
`default_nettype wire

/* core/pbs_params.svh */
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// word organisation: 256K words of four byte lanes, each lane with a parity bit
`define PBS_ADDR_W        18
`define PBS_DEPTH         262144
`define PBS_LANES         4
`define PBS_LANE_W        8
`define PBS_DATA_W        32
`define PBS_BURST_W       2

// burst order strap level that selects linear sequencing
`define PBS_ORDER_LINEAR  1'h0

// reset and idle levels, and the one-step burst increment
`define PBS_OE_N_IDLE     1'h1
`define PBS_SLEEP_IDLE    1'h0
`define PBS_ORDER_IDLE    1'h1
`define PBS_LOW_ZERO      2'h0
`define PBS_STEP_ONE      2'h1
`define PBS_UPPER_ZERO    16'h0000
`define PBS_DATA_ZERO     32'h0000_0000
`define PBS_PAR_ZERO      4'h0
`define PBS_MASK_NONE     4'hf

`endif

/* core/pbs_pkg.sv */
package pbs_pkg;

   // access type carried down the pipeline and held for a whole burst
   typedef enum logic [1:0] {
      PBS_IDLE,
      PBS_READ,
      PBS_WRITE
   } pbs_cmd_t;

endpackage

/* core/pbs_burst_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"

module pbs_burst_seq (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      load,
   input  wire logic                      advance,
   input  wire logic [`PBS_BURST_W-1:0]   start_low,
   input  wire logic                      order,
   output logic      [`PBS_BURST_W-1:0]   next_low
);

   logic [`PBS_BURST_W-1:0] start;
   logic [`PBS_BURST_W-1:0] count;
   logic [`PBS_BURST_W-1:0] count_inc;

   assign count_inc = count + `PBS_STEP_ONE;

   // only the two lowest address bits are sequenced; both orders wrap by width
   assign next_low = (order == `PBS_ORDER_LINEAR) ? start + count_inc
                                                  : start ^ count_inc;

   always_ff @(posedge clk) begin
      if (rst) begin
         start <= `PBS_LOW_ZERO;
         count <= `PBS_LOW_ZERO;
      end else if (load) begin
         start <= start_low;
         count <= `PBS_LOW_ZERO;
      end else if (advance) begin
         count <= count_inc;
      end
   end

endmodule
`default_nettype wire

/* core/pbs_core_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"

module pbs_core_mem (
   input  wire logic                      clk,
   input  wire logic                      wr_en,
   input  wire logic [`PBS_ADDR_W-1:0]    wr_addr,
   input  wire logic [`PBS_LANES-1:0]     wr_mask_n,
   input  wire logic [`PBS_DATA_W-1:0]    wr_data,
   input  wire logic [`PBS_LANES-1:0]     wr_par,
   input  wire logic [`PBS_ADDR_W-1:0]    rd_addr,
   output logic      [`PBS_DATA_W-1:0]    rd_data,
   output logic      [`PBS_LANES-1:0]     rd_par
);

   genvar g;
   generate
      for (g = 0; g < `PBS_LANES; g = g + 1) begin : lane
         logic [`PBS_LANE_W:0] store [0:`PBS_DEPTH-1];

         // a lane whose mask is high keeps its old byte
         always_ff @(posedge clk) begin
            if (wr_en && !wr_mask_n[g]) begin
               store[wr_addr] <= {wr_par[g], wr_data[g*`PBS_LANE_W +: `PBS_LANE_W]};
            end
         end

         assign rd_data[g*`PBS_LANE_W +: `PBS_LANE_W] = store[rd_addr][`PBS_LANE_W-1:0];
         assign rd_par[g] = store[rd_addr][`PBS_LANE_W];
      end
   endgenerate

endmodule
`default_nettype wire

/* test/pbs_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pbs_ctrl_model (
   input  wire logic        clk,
   output var  logic        clock_qualify_n,
   output var  logic        select_one_n,
   output var  logic        select_two,
   output var  logic        select_three_n,
   output var  logic        advance_or_load,
   output var  logic        write_strobe_n,
   output var  logic [3:0]  byte_lane_mask_n,
   output var  logic [17:0] address,
   output var  logic        output_drive_n,
   output var  logic        sleep_request,
   output var  logic        burst_order,
   output var  logic [35:0] wdata
);
   logic [1:0]  typ;
   logic [36:0] cur, p1, p2;
   logic        oe_v, sl_v, or_v;

   initial begin
      {clock_qualify_n, select_one_n, select_two, select_three_n} = 4'h5;
      {advance_or_load, write_strobe_n, byte_lane_mask_n} = 6'h1f;
      address = '0;
      {oe_v, sl_v, or_v, output_drive_n, sleep_request, burst_order} = 6'h09;
      {typ, cur, p1, p2, wdata} = '0;
   end

   // write data goes out two qualified edges after its address; idle bus toggles
   always @(posedge clk) begin
      if (!clock_qualify_n) begin
         p2 = p1;
         p1 = cur;
      end
      #1;
      wdata = p2[36] ? p2[35:0] : ~wdata;
   end

   // kind: 0 deselect, 1 read, 2 write, 3 advance, 4 stalled edge
   task automatic op(input int k, input logic [17:0] a, input logic [3:0] m,
                     input logic [35:0] d);
      logic [3:0] r;
      r = 4'($urandom);
      clock_qualify_n = (k == 4);
      advance_or_load = (k == 3);
      {select_one_n, select_two, select_three_n} = (k == 1 || k == 2) ? 3'h2 :
         (k == 0) ? 3'h2 ^ (3'h1 << (r % 3)) : r[2:0];
      write_strobe_n = (k == 2) ? 1'h0 : (k == 1) ? 1'h1 : r[3];
      address = (k == 1 || k == 2) ? a : 18'($urandom);
      byte_lane_mask_n = m;
      {output_drive_n, sleep_request, burst_order} = {oe_v, sl_v, or_v};
      if (k < 3) typ = 2'(k);
      cur = {typ == 2'h2, d};
      @(posedge clk);
   endtask

   task automatic pins(input logic o, input logic z, input logic r);
      {oe_v, sl_v, or_v} = {o, z, r};
   endtask
endmodule

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        clk, rst, q_n, s1_n, s2, s3_n, adv, we_n, oe_n, slp, ord;
   logic        doe_n, poe_n, sl_act, oe_now, sl_now, ord_now;
   logic [3:0]  mask_n, pout;
   logic [17:0] addr, b_a;
   logic [31:0] dout;
   logic [35:0] wd;
   logic [35:0] mem [logic [17:0]];
   logic [36:0] qp [2];
   logic [58:0] wp [2];
   int          b_typ, n_beat, age, n_errors, n_compared;

   pbs_sram_access u_pbs_sram_access (
      .CLK(clk), .RST(rst), .CLOCK_QUALIFY_N(q_n), .SELECT_ONE_N(s1_n),
      .SELECT_TWO(s2), .SELECT_THREE_N(s3_n), .ADVANCE_OR_LOAD(adv),
      .WRITE_STROBE_N(we_n), .BYTE_LANE_MASK_N(mask_n), .ADDRESS(addr),
      .OUTPUT_DRIVE_N(oe_n), .SLEEP_REQUEST(slp), .BURST_ORDER(ord),
      .DATA_IN(wd[31:0]), .DATA_OUT(dout), .DATA_OE_N(doe_n),
      .PARITY_IN(wd[35:32]), .PARITY_OUT(pout), .PARITY_OE_N(poe_n),
      .SLEEP_ACTIVE(sl_act)
   );
   pbs_ctrl_model u_pbs_ctrl_model (
      .clk(clk), .clock_qualify_n(q_n), .select_one_n(s1_n), .select_two(s2),
      .select_three_n(s3_n), .advance_or_load(adv), .write_strobe_n(we_n),
      .byte_lane_mask_n(mask_n), .address(addr), .output_drive_n(oe_n),
      .sleep_request(slp), .burst_order(ord), .wdata(wd)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [1:0] seq(input logic [1:0] s, input int n, input logic o);
      return o ? s ^ 2'(n) : s + 2'(n);
   endfunction

   function automatic logic [35:0] rdm(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : 36'hx;
   endfunction

   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                         input logic [3:0] m);
      for (int g = 0; g < 4; g++) begin
         if (!m[g]) begin
            o[8*g +: 8] = n[8*g +: 8];
            o[32+g] = n[32+g];
         end
      end
      return o;
   endfunction

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic pins(input logic o, input logic z, input logic r);
      {oe_now, sl_now, ord_now} = {o, z, r};
      age = 0;
      u_pbs_ctrl_model.pins(o, z, r);
   endtask

   // checks what the edge before last produced, then issues one command
   task automatic step(input int k, input logic [17:0] a, input logic [3:0] m,
                       input logic [35:0] d);
      logic [17:0] ea;
      logic [35:0] rd;
      #1;
      if (qp[1][36] && !$isunknown(qp[1][35:0])) chk({pout, dout}, qp[1][35:0]);
      if (age > 3) chk(36'({doe_n, poe_n, sl_act}),
                       36'({{2{!(qp[1][36] && !oe_now)}}, sl_now}));
      age++;
      if (k != 4) begin
         if (k == 3) begin
            n_beat++;
         end else begin
            b_a = a;
            n_beat = 0;
            b_typ = k;
         end
         ea = {b_a[17:2], seq(b_a[1:0], n_beat, ord_now)};
         // writes land two commands late, so the one just before is not yet seen
         if (wp[1][58]) mem[wp[1][57:40]] = merge(rdm(wp[1][57:40]), wp[1][35:0], wp[1][39:36]);
         rd = rdm(ea);
         wp[1] = wp[0];
         wp[0] = {b_typ == 2, ea, m, d};
         qp[1] = qp[0];
         qp[0] = {b_typ == 1, rd};
      end
      u_pbs_ctrl_model.op(k, a, m, d);
   endtask

   initial begin
      #1_000_000;
      n_errors++;
      stop_test();
   end

   initial begin
      logic [17:0] a;
      int          k;
      rst = 1'b1;
      {qp[0], qp[1], wp[0], wp[1]} = '0;
      {b_a, b_typ, n_beat, age, n_errors, n_compared} = '0;
      {oe_now, sl_now, ord_now} = 3'h1;
      void'($urandom(8610));
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk({pout, dout}, 36'h0_0000_0000);
      chk(36'({doe_n, poe_n, sl_act}), 36'h6);
      @(posedge clk);
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         pins(1'b0, 1'b0, s[0]);
         repeat (4) step(0, '0, 4'hf, '0);
         a = {16'h2a50 + 16'(s), 2'(s)};
         for (int i = 0; i < 4; i++) step(i ? 3 : 2, a, 4'h0, 36'({$urandom, $urandom}));
         for (int i = 0; i < 6; i++) step(i ? 3 : 1, a, 4'hf, '0);
         step(0, a, 4'hf, '0);
         step(3, a, 4'hf, '0);
         $display("test burst %0d done", s);
      end
      pins(1'b1, 1'b0, 1'b1);
      repeat (4) step(0, '0, 4'hf, '0);
      repeat (3) step(1, 18'h0_a940, 4'hf, '0);
      pins(1'b0, 1'b0, 1'b1);
      repeat (4) step(0, '0, 4'hf, '0);
      $display("test output enable done");
      pins(1'b0, 1'b1, 1'b1);
      repeat (6) step(0, '0, 4'hf, '0);
      pins(1'b0, 1'b0, 1'b1);
      repeat (5) step(0, '0, 4'hf, '0);
      for (int i = 0; i < 4; i++) step(1, 18'h0_a940 + 18'(i), 4'hf, '0);
      $display("test sleep done");
      for (int r = 0; r < 2; r++) begin
         pins(1'b0, 1'b0, r[0]);
         repeat (4) step(0, '0, 4'hf, '0);
         for (int i = 0; i < 250; i++) begin
            k = $urandom % 5;
            if (k == 3 && b_typ == 0) k = 1;
            step(k, 18'($urandom) & 18'h3_0007, 4'($urandom), 36'({$urandom, $urandom}));
         end
         $display("test random %0d done", r);
      end
      repeat (2) step(0, '0, 4'hf, '0);
      stop_test();
   end
endmodule

`default_nettype wire
